/* hw/shared_interrupt_pin_mux.sv */
// Shared interrupt pin multiplexer with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module shared_interrupt_pin_mux
  import pin_mux_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_axi_awaddr,
  input  wire logic        i_axi_awvalid,
  output logic             o_axi_awready,
  input  wire logic [31:0] i_axi_wdata,
  input  wire logic [3:0]  i_axi_wstrb,
  input  wire logic        i_axi_wvalid,
  output logic             o_axi_wready,
  output logic [1:0]       o_axi_bresp,
  output logic             o_axi_bvalid,
  input  wire logic        i_axi_bready,
  input  wire logic [7:0]  i_axi_araddr,
  input  wire logic        i_axi_arvalid,
  output logic             o_axi_arready,
  output logic [31:0]      o_axi_rdata,
  output logic [1:0]       o_axi_rresp,
  output logic             o_axi_rvalid,
  input  wire logic        i_axi_rready,
  input  wire logic [7:0]  i_sw_irq,
  input  wire logic [7:0]  i_timer_irq,
  input  wire logic [11:0] i_chain_irq,
  input  wire logic [11:0] i_pin_in,
  output logic [11:0]      o_pin_out,
  output logic [11:0]      o_pin_oe,
  output logic [11:0]      o_term_en,
  output logic [11:0]      o_edge_pulse,
  output logic             o_time_code,
  output logic             o_time_code_en,
  output logic             o_refclk,
  output logic             o_refclk_priority
);

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = data[8*b +: 8];
      end
    end
    return m;
  endfunction

  // Select-register index: bit 4 flags a hit
  function automatic logic [4:0] sel_hit(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_SEL0;
    return {(a >= ADDR_SEL0) && (d[7:2] < 6'(NUM_PINS)), d[5:2]};
  endfunction

  logic [11:0] dir_reg, term_reg, edge_reg, pulse_reg, pin_out_reg;
  logic [11:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [5:0]  sel_reg [NUM_PINS];
  logic [12:0] assign_reg;
  logic        tc_reg, rc_reg, rc_pri_reg, tc_en_reg;
  logic        aw_full_reg, w_full_reg, awready_reg, wready_reg;
  logic        bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, wdata_reg;
  logic [7:0]  awaddr_reg;
  logic [3:0]  wstrb_reg;

  // Bus handshakes and write decode
  wire aw_hs  = i_axi_awvalid & awready_reg;
  wire w_hs   = i_axi_wvalid & wready_reg;
  wire ar_hs  = i_axi_arvalid & arready_reg;
  wire wr_do  = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire [4:0] w_sel = sel_hit(awaddr_reg);
  wire [4:0] r_sel = sel_hit(i_axi_araddr);
  wire wr_dir  = wr_do && awaddr_reg == ADDR_DIR;
  wire wr_term = wr_do && awaddr_reg == ADDR_TERM;
  wire wr_edge = wr_do && awaddr_reg == ADDR_EDGE;
  wire wr_asg  = wr_do && awaddr_reg == ADDR_ASSIGN;
  wire w_ok    = wr_dir | wr_term | wr_edge | wr_asg | (wr_do & w_sel[4])
               | (wr_do && awaddr_reg == ADDR_LEVEL);
  wire [31:0] wmask = merge(32'h0, 32'hffffffff, wstrb_reg);
  // Merged words for the byte-lane writes of the config registers
  wire [31:0] dir_wr_word  = merge({20'h0, dir_reg}, wdata_reg, wstrb_reg);
  wire [31:0] term_wr_word = merge({20'h0, term_reg}, wdata_reg, wstrb_reg);
  wire [31:0] asg_wr_word  = merge({19'h0, assign_reg}, wdata_reg, wstrb_reg);

  wire aw_full_next = aw_hs | (aw_full_reg & ~wr_do);
  wire w_full_next  = w_hs | (w_full_reg & ~wr_do);
  wire bvalid_next  = wr_do | (bvalid_reg & ~i_axi_bready);
  wire rvalid_next  = ar_hs | (rvalid_reg & ~i_axi_rready);

  // Input synchroniser: a change counts once stages two and three agree
  wire [11:0] lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg ^ s3_reg));
  wire [11:0] rise     = lvl_next & ~lvl_reg;
  // Edge flags clear by writing one; a new edge wins over the clear
  wire [11:0] clr      = wr_edge ? (wdata_reg[11:0] & wmask[11:0]) : 12'h000;
  wire [11:0] edge_next = rise | (edge_reg & ~clr);

  // Source vector seen by every output multiplexer
  wire [SRC_COUNT-1:0] src_vec = {i_chain_irq, pulse_reg, i_timer_irq, i_sw_irq};
  wire [11:0] pin_out_next;
  genvar g;
  for (g = 0; g < NUM_PINS; g++) begin : g_mux
    // R3: source multiplexer
    assign pin_out_next[g] = (sel_reg[g] < SEL_W'(SRC_COUNT)) ? src_vec[sel_reg[g]] : 1'b0;
  end

  // R9: pin assignment of time-code and reference clock
  wire [3:0] tc_pin = assign_reg[TC_PIN_LSB +: 4];
  wire [3:0] rc_pin = assign_reg[RC_PIN_LSB +: 4];
  wire tc_on = assign_reg[TC_EN_BIT] && tc_pin < 4'(NUM_PINS);
  wire rc_on = assign_reg[RC_EN_BIT] && rc_pin < 4'(NUM_PINS);
  // R10: time-code level follows the chosen pin
  wire tc_next = tc_on ? lvl_reg[tc_pin] : 1'b0;
  wire rc_next = rc_on ? lvl_reg[rc_pin] : 1'b0;

  // Read data selection
  wire [31:0] rd_word =
    (i_axi_araddr == ADDR_DIR)    ? {20'h0, dir_reg}  :
    (i_axi_araddr == ADDR_TERM)   ? {20'h0, term_reg} :
    (i_axi_araddr == ADDR_LEVEL)  ? {20'h0, lvl_reg}  :
    (i_axi_araddr == ADDR_EDGE)   ? {20'h0, edge_reg} :
    (i_axi_araddr == ADDR_ASSIGN) ? {19'h0, assign_reg} :
    r_sel[4] ? {26'h0, sel_reg[r_sel[3:0]]} : 32'h0;
  wire rd_ok = (i_axi_araddr == ADDR_DIR) | (i_axi_araddr == ADDR_TERM)
             | (i_axi_araddr == ADDR_LEVEL) | (i_axi_araddr == ADDR_EDGE)
             | (i_axi_araddr == ADDR_ASSIGN) | r_sel[4];

  // Write channel holding registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= ~aw_full_next & ~bvalid_next;
      wready_reg  <= ~w_full_next & ~bvalid_next;
      bvalid_reg  <= bvalid_next;
      if (aw_hs) begin
        awaddr_reg <= {i_axi_awaddr[7:2], 2'b00};
      end
      if (w_hs) begin
        wdata_reg <= i_axi_wdata;
        wstrb_reg <= i_axi_wstrb;
      end
      if (wr_do) begin
        bresp_reg <= w_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Read channel
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= RESP_OKAY;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_hs) begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // R6: pins 0-5 both ways, 6-11 input only
      dir_reg    <= DIR_RESET;
      term_reg   <= TERM_RESET;
      assign_reg <= ASSIGN_RESET;
    end else begin
      // R1: per-pin direction
      if (wr_dir) begin
        dir_reg <= dir_wr_word[11:0];
      end
      // R2: per-pin termination
      if (wr_term) begin
        term_reg <= term_wr_word[11:0];
      end
      if (wr_asg) begin
        assign_reg <= asg_wr_word[12:0];
      end
    end
  end

  // Source select registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        sel_reg[i] <= SEL_RESET;
      end
    end else if (wr_do && w_sel[4] && wstrb_reg[0]) begin
      sel_reg[w_sel[3:0]] <= wdata_reg[SEL_W-1:0];
    end
  end

  // Pin input path and edge detection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg    <= 12'h000;
      s2_reg    <= 12'h000;
      s3_reg    <= 12'h000;
      lvl_reg   <= 12'h000;
      pulse_reg <= 12'h000;
      edge_reg  <= 12'h000;
    end else begin
      // R12: three-stage synchroniser
      s1_reg    <= i_pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      lvl_reg   <= lvl_next;
      // R7: rising edges raise interrupt flags
      pulse_reg <= rise;
      edge_reg  <= edge_next;
    end
  end

  // Pin drive and clock-source outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_out_reg <= 12'h000;
      tc_reg      <= 1'b0;
      rc_reg      <= 1'b0;
      rc_pri_reg  <= 1'b0;
    end else begin
      pin_out_reg <= pin_out_next;
      tc_reg      <= tc_next;
      rc_reg      <= rc_next;
      // R11: assigned reference clock overrides other sources
      rc_pri_reg  <= rc_on;
    end
  end

  assign o_axi_awready = awready_reg;
  assign o_axi_wready  = wready_reg;
  assign o_axi_bvalid  = bvalid_reg;
  assign o_axi_bresp   = bresp_reg;
  assign o_axi_arready = arready_reg;
  assign o_axi_rvalid  = rvalid_reg;
  assign o_axi_rdata   = rdata_reg;
  assign o_axi_rresp   = rresp_reg;
  // R4: driver gate only; input path stays live
  // R5: with enable high the pin reads back its own drive
  assign o_pin_oe      = dir_reg;
  assign o_pin_out     = pin_out_reg;
  assign o_term_en     = term_reg;
  assign o_edge_pulse  = pulse_reg;
  assign o_time_code   = tc_reg;
  assign o_time_code_en = tc_en_reg;
  // Registered time-code enable, valid pin assignment only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tc_en_reg <= 1'b0;
    end else begin
      tc_en_reg <= tc_on;
    end
  end
  assign o_refclk          = rc_reg;
  assign o_refclk_priority = rc_pri_reg;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence pin0_high3;
    i_pin_in[0] [*3];
  endsequence

  a_reset_dir: assert property ($rose(i_rst_n) |-> o_pin_oe == DIR_RESET) // R6
    else $error("direction not at reset default");
  a_dir_write: assert property (wr_dir && wstrb_reg == 4'hf // R1
    |=> o_pin_oe == $past(wdata_reg[11:0]))
    else $error("direction write lost");
  a_term_write: assert property (wr_term && wstrb_reg == 4'hf // R2
    |=> o_term_en == $past(wdata_reg[11:0]))
    else $error("termination write lost");
  a_mux_pin0: assert property (sel_reg[0] == 6'h00 |=> o_pin_out[0] == $past(i_sw_irq[0])) // R3
    else $error("pin 0 drive mismatch");
  a_sync_lvl: assert property (pin0_high3 |-> ##2 lvl_reg[0]) // R12
    else $error("input level not seen after sync");
  a_edge_flag: assert property ($rose(lvl_reg[0]) |-> edge_reg[0] && o_edge_pulse[0]) // R7
    else $error("edge not flagged");
  a_set_wins: assert property (rise[0] && clr[0] |=> edge_reg[0]) // R7
    else $error("edge lost to clear");
  a_tc_follow: assert property (tc_on && tc_pin == 4'h4 // R10
    |=> o_time_code == $past(lvl_reg[4]))
    else $error("time code not following pin");
  a_rc_prio: assert property (rc_on && rc_pin == 4'h5 // R11
    |=> o_refclk_priority && o_refclk == $past(lvl_reg[5]))
    else $error("reference clock priority missing");
  a_bvalid_hold: assert property (o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid) // bus write response hold
    else $error("write response dropped");

endmodule
`default_nettype wire

/* hw/pin_mux_pkg.sv */
// Constants for the shared interrupt pin multiplexer
// What this block does
// R1: Twelve pins, each set as input or output
// R2: Per-pin switchable line termination
// R3: Output pins driven by selectable interrupt source
// R4: Input path always on, output gated
// R5: Driven output loops back into input path
// R6: Reset: pins 0-5 in/out, 6-11 input
// R7: Pin inputs feed edge-triggered interrupts
// R8: External pulses should last about 1 us
// R9: Time-code and reference clock assignable to pins
// R10: Time-code assignment enables time-code reception
// R11: Assigned reference clock takes disciplining priority
// R12: Inputs synchronised before edge detection
package pin_mux_pkg;
  localparam int NUM_PINS = 12;
  localparam int SEL_W    = 6;
  // Register byte offsets
  localparam logic [7:0] ADDR_DIR    = 8'h00;
  localparam logic [7:0] ADDR_TERM   = 8'h04;
  localparam logic [7:0] ADDR_LEVEL  = 8'h08;
  localparam logic [7:0] ADDR_EDGE   = 8'h0c;
  localparam logic [7:0] ADDR_ASSIGN = 8'h10;
  localparam logic [7:0] ADDR_SEL0   = 8'h40;
  // Reset values
  localparam logic [11:0] DIR_RESET    = 12'h03f;
  localparam logic [11:0] TERM_RESET   = 12'h000;
  localparam logic [12:0] ASSIGN_RESET = 13'h0000;
  localparam logic [5:0]  SEL_RESET    = 6'h3f;
  // Assignment register fields
  localparam int TC_PIN_LSB = 0;
  localparam int TC_EN_BIT  = 4;
  localparam int RC_PIN_LSB = 8;
  localparam int RC_EN_BIT  = 12;
  // Source vector layout
  localparam int SRC_SW_BASE    = 0;
  localparam int SRC_TMR_BASE   = 8;
  localparam int SRC_EDGE_BASE  = 16;
  localparam int SRC_CHAIN_BASE = 28;
  localparam int SRC_COUNT      = 40;
  // Recommended external pulse width
  localparam int CLK_NS       = 10;
  localparam int PULSE_NS     = 1000;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* sim/pin_partner.sv */
// Far-side equipment model: drives pins and resolves each wire level
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic        i_clk,
  input  wire logic [11:0] i_pin_out,
  input  wire logic [11:0] i_pin_oe,
  input  wire logic [11:0] i_ext_en,
  input  wire logic [11:0] i_ext_val,
  output logic [11:0]      o_pin_in
);
  logic [11:0] float_reg = 12'h000;
  // A released line with no pull wanders every cycle
  always_ff @(posedge i_clk) begin
    float_reg <= ~float_reg;
  end
  // own drive loops back when nothing is attached
  assign o_pin_in = (i_ext_en & i_ext_val) | (~i_ext_en & i_pin_oe & i_pin_out)
                  | (~i_ext_en & ~i_pin_oe & float_reg);
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking testbench for the shared interrupt pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pin_mux_pkg::*;
;
  typedef struct packed {
    logic [5:0] code; logic [7:0] sw; logic [7:0] tmr; logic [11:0] ch; logic exp;
  } row_t;
  // Source code, source levels and the pin value they should give
  row_t rows [8] = '{'{6'h03, 8'h08, 8'h00, 12'h000, 1'b1}, '{6'h03, 8'hf7, 8'h00, 12'h000, 1'b0},
    '{6'h0a, 8'h00, 8'h04, 12'h000, 1'b1}, '{6'h0f, 8'h00, 8'h7f, 12'h000, 1'b0},
    '{6'h1e, 8'h00, 8'h00, 12'h004, 1'b1}, '{6'h27, 8'h00, 8'h00, 12'h800, 1'b1},
    '{6'h28, 8'hff, 8'hff, 12'hfff, 1'b0}, '{6'h3f, 8'hff, 8'hff, 12'hfff, 1'b0}};
  logic        i_clk = 1'b0, i_rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, tc, tc_en, rc, rc_pri;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, sw = 8'h00, tmr = 8'h00;
  logic [11:0] chain = 12'h000, ext_en = 12'h000, ext_val = 12'h000;
  logic [11:0] pin_in, pin_out, pin_oe, term, pulse;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0]  bresp, rresp;
  int          n_mismatch = 0, cmp_count = 0, pcnt = 0;
  shared_interrupt_pin_mux u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
    .o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(4'hf), .i_axi_wvalid(wvalid),
    .o_axi_wready(wready), .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
    .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
    .i_sw_irq(sw), .i_timer_irq(tmr), .i_chain_irq(chain), .i_pin_in(pin_in),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_term_en(term), .o_edge_pulse(pulse),
    .o_time_code(tc), .o_time_code_en(tc_en), .o_refclk(rc), .o_refclk_priority(rc_pri));
  pin_partner u_far (.i_clk(i_clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin_in(pin_in));
  // Clock and edge pulse counter for pin 6
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (pulse[6]) pcnt <= pcnt + 1;
  // Comparison, verdict and bounded wait
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge i_clk);
    n++;
    if (n > 60) begin
      n_mismatch++;
      conclude();
    end
  endtask
  // Bus write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    logic b;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      tick(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      b = bvalid;
    end while (!b);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
    // Let an edge pass so a following call never re-raises bready in this step
    @(posedge i_clk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    int n;
    logic b;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      tick(n);
      if (arready) arvalid <= 1'b0;
      b = rvalid;
    end while (!b);
    rready <= 1'b0;
    v = rdata;
    chk(32'(rresp), 32'(er));
    // Let an edge pass so a following call never re-raises rready in this step
    @(posedge i_clk);
  endtask
  task automatic waitc(input int c);
    repeat (c) @(posedge i_clk);
  endtask
  // Main sequence
  initial begin
    waitc(2);
    i_rst_n <= 1'b1;
    waitc(1);
    chk(32'(pin_oe), 32'h03f);
    chk(32'(term), 32'h0);
    axr(ADDR_DIR, d, RESP_OKAY);
    chk(d, 32'h03f);
    axr(ADDR_ASSIGN, d, RESP_OKAY);
    chk({d[31:0]} | 32'(tc_en) | 32'(rc_pri), 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      axw(8'(ADDR_SEL0 + 4 * i), 32'(rows[i].code), RESP_OKAY);
      sw <= rows[i].sw;
      tmr <= rows[i].tmr;
      chain <= rows[i].ch;
      waitc(3);
      chk(32'(pin_out[i]), 32'(rows[i].exp));
    end
    $display("test source select done");
    axw(ADDR_TERM, 32'h00000abc, RESP_OKAY);
    axw(ADDR_DIR, 32'h00000f0f, RESP_OKAY);
    waitc(2);
    chk(32'(term), 32'habc);
    chk(32'(pin_oe), 32'hf0f);
    // Loopback: pin 0 drives itself from software source 0
    sw <= 8'h01;
    axw(ADDR_SEL0, 32'h0, RESP_OKAY);
    waitc(8);
    axr(ADDR_LEVEL, d, RESP_OKAY);
    chk(d & 32'h1, 32'h1);
    sw <= 8'h00;
    waitc(8);
    axr(ADDR_LEVEL, d, RESP_OKAY);
    chk(d & 32'h1, 32'h0);
    $display("test config and loopback done");
    // Pin 6 held high for the recommended time, then a glitch
    ext_en <= 12'h070;
    ext_val <= 12'h040;
    waitc(PULSE_CYCLES);
    axr(ADDR_LEVEL, d, RESP_OKAY);
    chk(32'(d[6]), 32'h1);
    ext_val <= 12'h000;
    waitc(8);
    axr(ADDR_EDGE, d, RESP_OKAY);
    chk(32'(d[6]), 32'h1);
    ext_val <= 12'h040;
    waitc(1);
    ext_val <= 12'h000;
    waitc(8);
    chk(32'(pcnt), 32'h1);
    axw(ADDR_EDGE, 32'h40, RESP_OKAY);
    axr(ADDR_EDGE, d, RESP_OKAY);
    chk(32'(d[6]), 32'h0);
    $display("test edge input done");
    // Time-code on pin 4, reference clock on pin 5
    axw(ADDR_ASSIGN, 32'h1514, RESP_OKAY);
    ext_val <= 12'h030;
    waitc(8);
    chk(32'({tc_en, rc_pri}), 32'h3);
    chk(32'({tc, rc}), 32'h3);
    ext_val <= 12'h000;
    waitc(8);
    chk(32'({tc, rc}), 32'h0);
    $display("test assignment done");
    axw(8'h80, 32'h1, RESP_SLVERR);
    axr(8'h80, d, RESP_SLVERR);
    chk(d, 32'h0);
    i_rst_n <= 1'b0;
    waitc(2);
    i_rst_n <= 1'b1;
    waitc(1);
    chk(32'({pin_oe, term}), 32'h03f000);
    chk(32'({tc_en, rc_pri, tc, rc}), 32'h0);
    $display("test unmapped and reset done");
    conclude();
  end
endmodule
`default_nettype wire
